// file: modem_status_baud.sv
`timescale 1ns/1ps
module modem_status_baud (
    input wire logic clk,
    input wire logic rst_n,
    input wire modem_status_pkg::bus_req_type bus,
    output logic [7:0] rdata,
    input wire modem_status_pkg::modem_lines_type modem_n,
    output logic modem_int,
    output logic loopback,
    output logic baud16_tick
);
    // ========================================
    // Address decode shared by writes and reads
    function automatic modem_status_pkg::reg_sel_type reg_select(
        input logic [2:0] addr,
        input logic div_access
    );
        reg_select = modem_status_pkg::SEL_NONE;
        if (div_access && addr == modem_status_pkg::OFS_DIV_LOW) begin
            reg_select = modem_status_pkg::SEL_DIV_LOW;
        end else if (div_access && addr == modem_status_pkg::OFS_DIV_HIGH) begin
            reg_select = modem_status_pkg::SEL_DIV_HIGH;
        end else if (!div_access && addr == modem_status_pkg::OFS_INT_ENABLE) begin
            reg_select = modem_status_pkg::SEL_INT_ENABLE;
        end else if (addr == modem_status_pkg::OFS_LINE_CTRL) begin
            reg_select = modem_status_pkg::SEL_LINE_CTRL;
        end else if (addr == modem_status_pkg::OFS_MODEM_CTRL) begin
            reg_select = modem_status_pkg::SEL_MODEM_CTRL;
        end else if (addr == modem_status_pkg::OFS_MODEM_STATUS) begin
            reg_select = modem_status_pkg::SEL_MODEM_STATUS;
        end
    endfunction

    // ========================================
    // Control registers
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] divisor_low_byte;
    logic [7:0] divisor_high_byte;
    logic wr_q;
    logic reload;
    logic [7:0] next_line_control_reg;
    logic [7:0] next_modem_control_reg;
    logic [7:0] next_interrupt_enable_reg;
    logic [7:0] next_divisor_low_byte;
    logic [7:0] next_divisor_high_byte;
    logic next_wr_q;
    logic next_reload;
    logic div_access;
    logic wr_start;
    modem_status_pkg::reg_sel_type wr_sel;

    assign div_access = line_control_reg[modem_status_pkg::LINE_DIV_ACCESS_BIT];
    assign wr_start = bus.sel && bus.wr && !wr_q;
    assign wr_sel = reg_select(bus.addr, div_access);

    // Take each write on the leading cycle of the write strobe
    always_comb begin
        next_line_control_reg = line_control_reg;
        next_modem_control_reg = modem_control_reg;
        next_interrupt_enable_reg = interrupt_enable_reg;
        next_divisor_low_byte = divisor_low_byte;
        next_divisor_high_byte = divisor_high_byte;
        next_wr_q = bus.sel && bus.wr;
        next_reload = 1'b0;
        if (wr_start) begin
            unique case (wr_sel)
                modem_status_pkg::SEL_DIV_LOW: begin
                    next_divisor_low_byte = bus.wdata;
                    next_reload = 1'b1;
                end
                modem_status_pkg::SEL_DIV_HIGH: begin
                    next_divisor_high_byte = bus.wdata;
                    next_reload = 1'b1;
                end
                modem_status_pkg::SEL_INT_ENABLE: begin
                    next_interrupt_enable_reg = bus.wdata & modem_status_pkg::IEN_MASK;
                end
                modem_status_pkg::SEL_LINE_CTRL: begin
                    next_line_control_reg = bus.wdata;
                end
                modem_status_pkg::SEL_MODEM_CTRL: begin
                    next_modem_control_reg = bus.wdata & modem_status_pkg::MCTL_MASK;
                end
                modem_status_pkg::SEL_MODEM_STATUS: begin
                    next_wr_q = 1'b1; // Status writes are dropped
                end
                modem_status_pkg::SEL_NONE: begin
                    next_wr_q = 1'b1;
                end
            endcase
        end
    end

    // Register control state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line_control_reg <= modem_status_pkg::BYTE_RESET;
            modem_control_reg <= modem_status_pkg::BYTE_RESET;
            interrupt_enable_reg <= modem_status_pkg::BYTE_RESET;
            divisor_low_byte <= modem_status_pkg::DIV_RESET[7:0];
            divisor_high_byte <= modem_status_pkg::DIV_RESET[15:8];
            wr_q <= 1'b0;
            reload <= 1'b0;
        end else begin
            line_control_reg <= next_line_control_reg;
            modem_control_reg <= next_modem_control_reg;
            interrupt_enable_reg <= next_interrupt_enable_reg;
            divisor_low_byte <= next_divisor_low_byte;
            divisor_high_byte <= next_divisor_high_byte;
            wr_q <= next_wr_q;
            reload <= next_reload;
        end
    end

    assign loopback = modem_control_reg[modem_status_pkg::MCTL_LOOP_BIT];

    // ========================================
    // Modem input synchroniser
    modem_status_pkg::modem_lines_type sync_a;
    modem_status_pkg::modem_lines_type sync_b;
    modem_status_pkg::modem_lines_type next_sync_a;
    modem_status_pkg::modem_lines_type next_sync_b;

    // Two stages; only the second stage is looked at
    always_comb begin
        next_sync_a = modem_n;
        next_sync_b = sync_a;
    end

    // Register synchroniser, idling at inactive high pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_a <= modem_status_pkg::PINS_IDLE;
            sync_b <= modem_status_pkg::PINS_IDLE;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // ========================================
    // Level and change tracking
    logic [3:0] level_now;
    logic [3:0] level;
    logic [3:0] delta;
    logic [3:0] pend;
    logic [3:0] event_now;
    logic rd_q;
    logic rd_active;
    logic rd_end;
    logic [3:0] next_level;
    logic [3:0] next_delta;
    logic [3:0] next_pend;
    logic next_rd_q;
    logic next_modem_int;

    // Loopback replaces the pins by control bits, else pins inverted
    always_comb begin
        if (loopback) begin
            level_now[modem_status_pkg::LINE_CTS] =
                modem_control_reg[modem_status_pkg::MCTL_RTS_BIT];
            level_now[modem_status_pkg::LINE_DSR] =
                modem_control_reg[modem_status_pkg::MCTL_DTR_BIT];
            level_now[modem_status_pkg::LINE_RI] =
                modem_control_reg[modem_status_pkg::MCTL_USER_ONE_BIT];
            level_now[modem_status_pkg::LINE_DCD] =
                modem_control_reg[modem_status_pkg::MCTL_USER_TWO_BIT];
        end else begin
            level_now = ~sync_b;
        end
    end

    // Change events; ring counts only the pin's low to high edge
    always_comb begin
        event_now = level ^ level_now;
        event_now[modem_status_pkg::LINE_RI] = level[modem_status_pkg::LINE_RI]
            && !level_now[modem_status_pkg::LINE_RI];
    end

    assign rd_active = bus.sel && bus.rd && bus.addr == modem_status_pkg::OFS_MODEM_STATUS;
    assign rd_end = rd_q && !rd_active;

    // Change flags: hold during read, resolve at its trailing edge
    always_comb begin
        next_level = level_now;
        next_delta = delta;
        next_pend = pend;
        next_rd_q = rd_active;
        if (rd_active) begin
            next_pend = pend | event_now;
        end else if (rd_end) begin
            next_delta = (pend | event_now) & ~delta;
            next_pend = 4'h0;
        end else begin
            next_delta = delta | event_now;
        end
        next_modem_int = interrupt_enable_reg[modem_status_pkg::IEN_MODEM_BIT]
            && (|delta);
    end

    // Register level, flags and interrupt
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level <= 4'h0;
            delta <= 4'h0;
            pend <= 4'h0;
            rd_q <= 1'b0;
            modem_int <= 1'b0;
        end else begin
            level <= next_level;
            delta <= next_delta;
            pend <= next_pend;
            rd_q <= next_rd_q;
            modem_int <= next_modem_int;
        end
    end

    // ========================================
    // Read data
    logic [7:0] next_rdata;
    modem_status_pkg::reg_sel_type rd_sel;

    assign rd_sel = reg_select(bus.addr, div_access);

    // Capture the addressed register while the read strobe is high
    always_comb begin
        next_rdata = rdata;
        if (bus.sel && bus.rd) begin
            unique case (rd_sel)
                modem_status_pkg::SEL_DIV_LOW: next_rdata = divisor_low_byte;
                modem_status_pkg::SEL_DIV_HIGH: next_rdata = divisor_high_byte;
                modem_status_pkg::SEL_INT_ENABLE: next_rdata = interrupt_enable_reg;
                modem_status_pkg::SEL_LINE_CTRL: next_rdata = line_control_reg;
                modem_status_pkg::SEL_MODEM_CTRL: next_rdata = modem_control_reg;
                modem_status_pkg::SEL_MODEM_STATUS: next_rdata = {level, delta};
                modem_status_pkg::SEL_NONE: next_rdata = 8'h00;
            endcase
        end
    end

    // Register read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ========================================
    // Baud generator
    baud_counter u_baud (
        .clk(clk),
        .rst_n(rst_n),
        .divisor({divisor_high_byte, divisor_low_byte}),
        .reload(reload),
        .tick(baud16_tick)
    );

    // ========================================
    // Checks
    AST_CTS_CHANGE_SETS: assert property (@(posedge clk) disable iff (!rst_n)
        (!rd_active && !rd_end && level_now[0] != level[0]) |=> delta[0])
        else $error("cts change flag not set");

    AST_RING_FALL_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
        (!rd_active && !rd_end && !delta[2] && !(level[2] && !level_now[2])) |=> !delta[2])
        else $error("ring flag set without trailing edge");

    AST_PIN_INVERTED: assert property (@(posedge clk) disable iff (!rst_n)
        !loopback |=> level == ~$past(sync_b))
        else $error("status level not inverted pin");

    AST_LOOP_LEVELS: assert property (@(posedge clk) disable iff (!rst_n)
        loopback |=> level == {$past(modem_control_reg[3]), $past(modem_control_reg[2]),
            $past(modem_control_reg[0]), $past(modem_control_reg[1])})
        else $error("loopback status does not follow control bits");

    AST_INT_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        (interrupt_enable_reg[3] && delta != 4'h0) |=> modem_int)
        else $error("modem interrupt not raised");

    AST_READ_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
        rd_end |=> (delta & $past(delta)) == 4'h0)
        else $error("change flag not cleared at read end");

    AST_HOLD_IN_READ: assert property (@(posedge clk) disable iff (!rst_n)
        rd_active |=> delta == $past(delta))
        else $error("change flag moved during read");

    AST_PEND_LANDS: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_end && !delta[1] && (pend[1] || event_now[1])) |=> delta[1])
        else $error("deferred dsr change lost");

    AST_DIV_GUARDED: assert property (@(posedge clk) disable iff (!rst_n)
        (bus.sel && bus.wr && !div_access) |=> $stable(divisor_low_byte))
        else $error("divisor written without access bit");

    AST_RING_RISE_SETS: assert property (@(posedge clk) disable iff (!rst_n)
        (!rd_active && !rd_end && level[2] && !level_now[2]) |=> delta[2])
        else $error("ring flag not set on trailing edge");

    AST_INT_DROPS: assert property (@(posedge clk) disable iff (!rst_n)
        (!interrupt_enable_reg[3] || delta == 4'h0) |=> !modem_int)
        else $error("modem interrupt raised without enabled flag");
endmodule // modem_status_baud

// file: modem_status_pkg.sv
package modem_status_pkg;
    // ========================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SAMPLES_PER_BIT = 16;

    // ========================================
    // Register offsets on the parallel bus
    localparam logic [2:0] OFS_DIV_LOW = 3'h0;
    localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
    localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
    localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
    localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
    localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;

    // ========================================
    // Field positions
    localparam int LINE_DIV_ACCESS_BIT = 7;
    localparam int MCTL_DTR_BIT = 0;
    localparam int MCTL_RTS_BIT = 1;
    localparam int MCTL_USER_ONE_BIT = 2;
    localparam int MCTL_USER_TWO_BIT = 3;
    localparam int MCTL_LOOP_BIT = 4;
    localparam int IEN_MODEM_BIT = 3;
    localparam int LINE_CTS = 0;
    localparam int LINE_DSR = 1;
    localparam int LINE_RI = 2;
    localparam int LINE_DCD = 3;

    // ========================================
    // Reset values and masks
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    localparam logic [7:0] MCTL_MASK = 8'h1F;
    localparam logic [7:0] IEN_MASK = 8'h0F;
    localparam logic [3:0] PINS_IDLE = 4'hF;

    // ========================================
    // Types
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } modem_lines_type;

    typedef struct packed {
        logic sel;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bus_req_type;

    typedef enum {
        SEL_NONE,
        SEL_DIV_LOW,
        SEL_DIV_HIGH,
        SEL_INT_ENABLE,
        SEL_LINE_CTRL,
        SEL_MODEM_CTRL,
        SEL_MODEM_STATUS
    } reg_sel_type;
endpackage

// file: baud_counter.sv
`timescale 1ns/1ps
module baud_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] divisor,
    input wire logic reload,
    output logic tick
);
    // ========================================
    // Down counter
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic next_tick;

    // Count from the divisor to one, giving one tick per divisor cycles
    always_comb begin
        next_cnt = cnt;
        next_tick = 1'b0;
        if (reload) begin
            next_cnt = divisor;
        end else if (divisor == 16'h0000) begin
            next_cnt = 16'h0000; // Idle until a divisor is loaded
        end else if (cnt <= 16'h0001) begin
            next_cnt = divisor;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt - 16'h0001;
        end
    end

    // Register the counter and tick
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= modem_status_pkg::DIV_RESET;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end

    // ========================================
    // Checks
    AST_RELOAD_NOW: assert property (@(posedge clk) disable iff (!rst_n)
        reload |=> (cnt == $past(divisor)) && !tick)
        else $error("baud counter not reloaded on divisor write");

    AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
        (cnt == 16'h0001 && !reload && divisor != 16'h0000) |=> tick && cnt == $past(divisor))
        else $error("baud tick missing at end of count");

    AST_NO_EARLY_TICK: assert property (@(posedge clk) disable iff (!rst_n)
        (cnt > 16'h0001 && !reload) |=> !tick)
        else $error("baud tick before count expired");
endmodule // baud_counter

// file: modem_peer.sv
`timescale 1ns/1ps
module modem_peer (
    input wire logic clk,
    input wire logic [3:0] want_n,
    output modem_status_pkg::modem_lines_type modem_n
);
    // ========================================
    // Modem handshake lines
    // Lines idle high, like pulled-up inputs with no modem attached
    initial modem_n = modem_status_pkg::PINS_IDLE;

    // Lines move on the rising edge, unrelated to the host bus timing
    always @(posedge clk) begin
        modem_n <= want_n;
    end
endmodule // modem_peer

// file: tb.sv
`timescale 1ns/1ps
module tb;
    // ========================================
    // Clock, reset and bench state
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    modem_status_pkg::bus_req_type bus = '0;
    logic [3:0] want_n = 4'hF;
    modem_status_pkg::modem_lines_type modem_n;
    logic [7:0] rdata;
    logic modem_int;
    logic loopback;
    logic baud16_tick;
    logic [31:0] seed = 32'h0583;
    logic [3:0] lv;
    logic [3:0] p;
    logic [3:0] nl;
    logic [3:0] ex;
    logic [7:0] d;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    int k;

    // Free-running clock, 5 ns period
    always #2.5 clk = ~clk;

    modem_status_baud dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .modem_n(modem_n), .modem_int(modem_int), .loopback(loopback),
        .baud16_tick(baud16_tick));

    modem_peer peer (.clk(clk), .want_n(want_n), .modem_n(modem_n));

    // ========================================
    // Expectation helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Change flags from old and new levels; ring flags only a level fall
    function automatic logic [3:0] delta_of(input logic [3:0] o, input logic [3:0] nw);
        return ((o ^ nw) & 4'hB) | (o & ~nw & 4'h4);
    endfunction

    // Loopback levels: carrier, ring, ready, clear-to-send
    function automatic logic [3:0] loop_lv(input logic [3:0] mc);
        return {mc[3], mc[2], mc[0], mc[1]};
    endfunction

    // ========================================
    // Compare tasks and closing report
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task final_report;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ========================================
    // Host bus tasks, driven on the falling edge
    task automatic bus_write(input logic [2:0] a, input logic [7:0] v);
        @(negedge clk);
        bus.sel = 1'h1;
        bus.wr = 1'h1;
        bus.addr = a;
        bus.wdata = v;
        @(negedge clk);
        bus = '0;
    endtask

    task automatic rd_start(input logic [2:0] a, output logic [7:0] v);
        @(negedge clk);
        bus.sel = 1'h1;
        bus.rd = 1'h1;
        bus.addr = a;
        @(negedge clk);
        v = rdata;
    endtask

    task automatic rd_stop;
        bus = '0;
        @(negedge clk);
    endtask

    task automatic bus_read(input logic [2:0] a, output logic [7:0] v);
        rd_start(a, v);
        rd_stop();
    endtask

    task automatic count_tick(output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (baud16_tick !== 1'h1 && c < 2000);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    // ========================================
    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        check_val({8'h00, rdata}, 16'h0000);
        check_bit(modem_int | loopback | baud16_tick, 1'h0);
        rst_n = 1'h1;
        $display("test reset done");

        // Divisor load, reload and tick spacing
        for (int i = 0; i < 6; i++) begin
            seed = xorshift(seed);
            n = (i == 0) ? 1 : (i == 1) ? 2 : (i == 2) ? 300 : int'(seed % 60) + 3;
            bus_write(modem_status_pkg::OFS_LINE_CTRL, 8'h80);
            bus_write(modem_status_pkg::OFS_DIV_HIGH, 8'h40);
            bus_write(modem_status_pkg::OFS_DIV_LOW, n[7:0]);
            bus_write(modem_status_pkg::OFS_DIV_HIGH, n[15:8]);
            count_tick(k);
            // Reload lands one edge after the write, first tick n edges later
            check_val(k[15:0], n[15:0] + 16'h0001);
            count_tick(k);
            check_val(k[15:0], n[15:0]);
            bus_read(modem_status_pkg::OFS_DIV_LOW, d);
            check_val({8'h00, d}, {8'h00, n[7:0]});
            bus_read(modem_status_pkg::OFS_DIV_HIGH, d);
            check_val({8'h00, d}, {8'h00, n[15:8]});
        end
        $display("test divisor done");

        // Divisor latches hidden while the access bit is clear
        bus_write(modem_status_pkg::OFS_LINE_CTRL, 8'h00);
        bus_read(modem_status_pkg::OFS_DIV_LOW, d);
        check_val({8'h00, d}, 16'h0000);
        bus_write(modem_status_pkg::OFS_DIV_LOW, 8'h55);
        bus_write(modem_status_pkg::OFS_INT_ENABLE, 8'hFF);
        bus_read(modem_status_pkg::OFS_INT_ENABLE, d);
        check_val({8'h00, d}, 16'h000F);
        bus_write(modem_status_pkg::OFS_LINE_CTRL, 8'h80);
        bus_read(modem_status_pkg::OFS_DIV_LOW, d);
        check_val({8'h00, d}, {8'h00, n[7:0]});
        bus_write(modem_status_pkg::OFS_LINE_CTRL, 8'h00);
        bus_write(modem_status_pkg::OFS_INT_ENABLE, 8'h08);
        $display("test access done");

        // Pin changes, corner patterns first, then random
        bus_read(modem_status_pkg::OFS_MODEM_STATUS, d);
        check_val({8'h00, d}, 16'h0000);
        lv = 4'h0;
        for (int i = 0; i < 16; i++) begin
            seed = xorshift(seed);
            p = (i == 0) ? 4'hB : (i == 1) ? 4'hF : (i == 2) ? 4'h0 : seed[3:0];
            ex = delta_of(lv, ~p);
            want_n = p;
            repeat (6) @(negedge clk);
            check_bit(modem_int, |ex);
            bus_read(modem_status_pkg::OFS_MODEM_STATUS, d);
            check_val({8'h00, d}, {8'h00, ~p, ex});
            bus_read(modem_status_pkg::OFS_MODEM_STATUS, d);
            check_val({8'h00, d}, {8'h00, ~p, 4'h0});
            check_bit(modem_int, 1'h0);
            lv = ~p;
        end
        $display("test pins done");

        // Events inside a long status read
        want_n = want_n ^ 4'h1;
        repeat (6) @(negedge clk);
        rd_start(modem_status_pkg::OFS_MODEM_STATUS, d);
        want_n = want_n ^ 4'h3;
        repeat (6) @(negedge clk);
        check_val({12'h000, rdata[3:0]}, 16'h0001);
        rd_stop();
        bus_read(modem_status_pkg::OFS_MODEM_STATUS, d);
        check_val({8'h00, d}, {8'h00, ~want_n, 4'h2});
        $display("test read window done");

        // Loopback: levels follow control bits, pins ignored
        bus_write(modem_status_pkg::OFS_MODEM_CTRL, 8'h10);
        repeat (6) @(negedge clk);
        bus_read(modem_status_pkg::OFS_MODEM_STATUS, d);
        check_bit(loopback, 1'h1);
        lv = 4'h0;
        for (int i = 0; i < 16; i++) begin
            seed = xorshift(seed);
            nl = loop_lv(i[3:0]);
            ex = delta_of(lv, nl);
            want_n = seed[3:0];
            bus_write(modem_status_pkg::OFS_MODEM_CTRL, {4'h1, i[3:0]});
            repeat (6) @(negedge clk);
            check_bit(modem_int, |ex);
            bus_read(modem_status_pkg::OFS_MODEM_STATUS, d);
            check_val({8'h00, d}, {8'h00, nl, ex});
            lv = nl;
        end
        $display("test loopback done");

        // Reset in mid-run clears outputs and stops the generator
        @(negedge clk);
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        check_bit(modem_int | loopback, 1'h0);
        k = 0;
        repeat (40) begin
            @(negedge clk);
            if (baud16_tick === 1'h1) begin
                k++;
            end
        end
        check_val(k[15:0], 16'h0000);
        $display("test second reset done");
        final_report();
    end
endmodule // tb
